// *** hw/ism_defines.svh ***
`ifndef ISM_DEFINES_SVH
`define ISM_DEFINES_SVH

// register byte offsets
`define ISM_CONFIG_OFS 4'h0
`define ISM_DEBUG_OFS 4'h4
`define ISM_STATUS_OFS 4'h8

// config register fields
`define ISM_AVAIL_LSB 14
`define ISM_AVAIL_MSB 15
`define ISM_EXCSEL_BIT 16
// debug register field
`define ISM_DBGSEL_BIT 0
// status register fields
`define ISM_STAT_MODE_BIT 0
`define ISM_STAT_ADDR_BIT 1
`define ISM_STAT_AVAIL_LSB 2

// mode bit values
`define ISM_MODE_FIXED32 1'b0
`define ISM_MODE_COMPACT 1'b1

// available-encodings field codes
`define ISM_AVAIL_ONLY32 2'h0
`define ISM_AVAIL_ONLYCMP 2'h1
`define ISM_AVAIL_BOTH32 2'h2
`define ISM_AVAIL_BOTHCMP 2'h3

// offset shift amounts
`define ISM_SHIFT_FIXED32 2'h2
`define ISM_SHIFT_COMPACT 2'h1

// reset values
`define ISM_RST_RDATA 32'h0000_0000
`define ISM_RST_TARGET 32'h0000_0000

`endif

// *** hw/ism_pkg.sv ***
package ism_pkg;

	typedef enum logic [1:0] {
		ISM_BUS_IDLE = 2'b01,
		ISM_BUS_ACK = 2'b10
	} ism_bus_state_t;

	typedef enum logic [1:0] {
		ISM_EXC_NORMAL = 2'h0,
		ISM_EXC_ERROR = 2'h1,
		ISM_EXC_DEBUG = 2'h2
	} ism_exc_kind_t;

endpackage

// *** hw/ism_sel_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

module ism_sel_mem #(
	parameter int DEPTH = 2,
	parameter int AW = 1
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic rst_val_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic wr_data_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic rd_data_out
);

	logic [DEPTH-1:0] mem_q;

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			mem_q <= {DEPTH{rst_val_in}};
			rd_data_out <= rst_val_in;
		end else begin
			if (wr_en_in) begin
				mem_q[wr_addr_in] <= wr_data_in;
			end
			rd_data_out <= mem_q[rd_addr_in];
		end
	end

endmodule

`default_nettype wire

// *** hw/ism_mode_switch.sv ***
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "ism_defines.svh"

// Notes on behaviour
// - available encodings readable at config bits 15:14
// - reset mode follows external available-encodings field
// - exception encoding select bit 16, external reset
// - debug encoding select bit, probe writable
// - one exception select per virtual processing element
// - mode 0 fixed 32-bit, 1 compact
// - exception saves mode into return address bit 0
// - exchange jump link toggles the mode
// - register jumps take mode from source bit 0
// - register jump link writes mode to link bit 0
// - exception entry sets mode from configured select on debug and base vectors, else from start mode
// - exception return restores mode from bit 0
// - single encoding keeps fixed mode bit
// - single encoding: exchange jump is reserved instruction
// - single encoding: mismatched jump faults at fetch
// - single encoding: link still carries fixed mode
// - compact mode shifts offsets left by one
// - 32-bit mode shifts offsets left by two
// - compact missing coprocessor: chosen exception kind
// - 32-bit missing coprocessor: coprocessor unusable
// - branch-likely only legal in 32-bit mode
module ism_mode_switch
	import ism_pkg::*;
#(
	parameter int NUM_VPE = 2,
	parameter int VPE_AW = 1,
	parameter int OFS_W = 26,
	parameter bit COMPACT_COP_RI = 1'b1
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [1:0] isa_avail_in,
	input wire logic exc_sel_rst_in,
	input wire logic dbg_sel_rst_in,
	input wire logic [VPE_AW-1:0] vpe_in,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic exchange_jump_link_in,
	input wire logic rjump_in,
	input wire logic rjump_link_in,
	input wire logic [31:0] rjump_src_in,
	input wire logic [31:0] link_addr_in,
	input wire logic exc_in,
	input wire ism_exc_kind_t exc_kind_in,
	input wire logic exc_base_vec_in,
	input wire logic [31:0] exc_pc_in,
	input wire logic eret_in,
	input wire logic [31:0] eret_addr_in,
	input wire logic fetch_in,
	input wire logic cop_missing_in,
	input wire logic [OFS_W-1:0] offset_in,
	output logic mode_out,
	output logic [31:0] jump_target_out,
	output logic [31:0] link_value_out,
	output logic [31:0] ret_addr_out,
	output logic [1:0] ret_kind_out,
	output logic ret_wr_out,
	output logic ri_exc_out,
	output logic addr_exc_out,
	output logic cop_unusable_out,
	output logic [31:0] offset_out,
	output logic branch_likely_ok_out
);

	////////////////////////////////////////////////////////////////////////////
	// decoding helpers

	function automatic logic avail_single(input logic [1:0] av);
		avail_single = (av == `ISM_AVAIL_ONLY32) || (av == `ISM_AVAIL_ONLYCMP);
	endfunction

	function automatic logic avail_start_mode(input logic [1:0] av);
		avail_start_mode = (av == `ISM_AVAIL_ONLYCMP) || (av == `ISM_AVAIL_BOTHCMP);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	logic mode_q;
	logic mode_d;
	logic [1:0] avail_q;
	logic dbg_sel_q;
	logic dbg_sel_d;
	logic addr_pend_q;
	logic addr_pend_d;
	logic [31:0] target_q;
	logic [31:0] link_q;
	logic [31:0] ret_q;
	logic [1:0] ret_kind_q;
	logic ret_wr_q;
	logic ri_q;
	logic addr_exc_q;
	logic cpu_q;
	logic [31:0] ofs_q;
	logic [31:0] rdata_q;
	ism_bus_state_t bus_q;
	ism_bus_state_t bus_d;

	////////////////////////////////////////////////////////////////////////////
	// register bus decode

	wire logic bus_req = avs_read | avs_write;
	wire logic bus_ack = (bus_q == ISM_BUS_ACK);
	wire logic hit_cfg = (avs_address == `ISM_CONFIG_OFS);
	wire logic hit_dbg = (avs_address == `ISM_DEBUG_OFS);
	wire logic hit_stat = (avs_address == `ISM_STATUS_OFS);
	wire logic wr_commit = avs_write & bus_ack;
	wire logic wr_excsel = wr_commit & hit_cfg & avs_byteenable[2];
	wire logic wr_dbgsel = wr_commit & hit_dbg & avs_byteenable[0];

	always_comb begin
		case (bus_q)
			ISM_BUS_IDLE: bus_d = bus_req ? ISM_BUS_ACK : ISM_BUS_IDLE;
			ISM_BUS_ACK: bus_d = ISM_BUS_IDLE;
			default: bus_d = ISM_BUS_IDLE;
		endcase
	end

	// one wait cycle lets read data come from a flop
	assign avs_waitrequest = bus_req & ~bus_ack;
	assign avs_readdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// per-element exception encoding select

	logic exc_sel_rd;

	ism_sel_mem #(
		.DEPTH(NUM_VPE),
		.AW(VPE_AW)
	) u_sel_mem (
		.ref_clk_in(ref_clk_in),
		.srst_in(srst_in),
		.rst_val_in(exc_sel_rst_in),
		.wr_en_in(wr_excsel),
		.wr_addr_in(vpe_in),
		.wr_data_in(avs_writedata[`ISM_EXCSEL_BIT]),
		.rd_addr_in(vpe_in),
		.rd_data_out(exc_sel_rd)
	);

	////////////////////////////////////////////////////////////////////////////
	// read mux

	logic [31:0] cfg_word;
	logic [31:0] dbg_word;
	logic [31:0] stat_word;

	always_comb begin
		cfg_word = 32'h0000_0000;
		cfg_word[`ISM_AVAIL_MSB:`ISM_AVAIL_LSB] = avail_q;
		cfg_word[`ISM_EXCSEL_BIT] = exc_sel_rd;
		dbg_word = 32'h0000_0000;
		dbg_word[`ISM_DBGSEL_BIT] = dbg_sel_q;
		stat_word = 32'h0000_0000;
		stat_word[`ISM_STAT_MODE_BIT] = mode_q;
		stat_word[`ISM_STAT_ADDR_BIT] = addr_pend_q;
		stat_word[`ISM_STAT_AVAIL_LSB +: 2] = avail_q;
	end

	wire logic [31:0] rd_mux = hit_cfg ? cfg_word :
		hit_dbg ? dbg_word :
		hit_stat ? stat_word : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// mode next-state

	wire logic single = avail_single(avail_q);
	wire logic src_mode = rjump_src_in[0];
	wire logic any_rjump = rjump_in | rjump_link_in;
	// debug entry uses the debug select; non-debug vectors off the base use the exception select; others use the start mode
	wire logic entry_mode = (exc_kind_in == ISM_EXC_DEBUG) ? dbg_sel_q :
		exc_base_vec_in ? exc_sel_rd : avail_start_mode(avail_q);
	wire logic mismatch = single & any_rjump & (src_mode != mode_q);

	// priority: exception entry, then return, then jumps
	always_comb begin
		mode_d = mode_q;
		if (single) begin
			mode_d = mode_q;
		end else if (exc_in) begin
			mode_d = entry_mode;
		end else if (eret_in) begin
			mode_d = eret_addr_in[0];
		end else if (any_rjump) begin
			mode_d = src_mode;
		end else if (exchange_jump_link_in) begin
			mode_d = ~mode_q;
		end
	end

	// pending fault waits for the target fetch; a new fault beats the fetch clear, an exception beats a new fault
	always_comb begin
		addr_pend_d = addr_pend_q;
		if (fetch_in | exc_in) begin
			addr_pend_d = 1'b0;
		end
		if (mismatch & ~exc_in) begin
			addr_pend_d = 1'b1;
		end
	end

	always_comb begin
		dbg_sel_d = dbg_sel_q;
		if (wr_dbgsel) begin
			dbg_sel_d = avs_writedata[`ISM_DBGSEL_BIT];
		end
	end

	// offset scaling by current encoding
	wire logic [31:0] ofs_ext = {{(32 - OFS_W){offset_in[OFS_W-1]}}, offset_in};
	wire logic [31:0] ofs_scaled = mode_q ? (ofs_ext << `ISM_SHIFT_COMPACT) :
		(ofs_ext << `ISM_SHIFT_FIXED32);

	////////////////////////////////////////////////////////////////////////////
	// flops

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			bus_q <= ISM_BUS_IDLE;
			rdata_q <= `ISM_RST_RDATA;
		end else begin
			bus_q <= bus_d;
			rdata_q <= rd_mux;
		end
	end

	// sync reset captures the straps at the reset edge
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			avail_q <= isa_avail_in;
			mode_q <= avail_start_mode(isa_avail_in);
			dbg_sel_q <= dbg_sel_rst_in;
			addr_pend_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			dbg_sel_q <= dbg_sel_d;
			addr_pend_q <= addr_pend_d;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			target_q <= `ISM_RST_TARGET;
			link_q <= `ISM_RST_TARGET;
		end else if (any_rjump) begin
			target_q <= {rjump_src_in[31:1], 1'b0};
			if (rjump_link_in) begin
				link_q <= {link_addr_in[31:1], mode_q};
			end
		end else if (exchange_jump_link_in & ~single) begin
			link_q <= {link_addr_in[31:1], mode_q};
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			ret_q <= `ISM_RST_TARGET;
			ret_kind_q <= ISM_EXC_NORMAL;
			ret_wr_q <= 1'b0;
		end else begin
			ret_wr_q <= exc_in;
			if (exc_in) begin
				ret_q <= {exc_pc_in[31:1], mode_q};
				ret_kind_q <= exc_kind_in;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			ri_q <= 1'b0;
			addr_exc_q <= 1'b0;
			cpu_q <= 1'b0;
			ofs_q <= `ISM_RST_TARGET;
		end else begin
			ri_q <= (exchange_jump_link_in & single) |
				(cop_missing_in & mode_q & COMPACT_COP_RI);
			addr_exc_q <= addr_pend_q & fetch_in & ~exc_in;
			cpu_q <= cop_missing_in & (~mode_q | ~COMPACT_COP_RI);
			ofs_q <= ofs_scaled;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign mode_out = mode_q;
	assign jump_target_out = target_q;
	assign link_value_out = link_q;
	assign ret_addr_out = ret_q;
	assign ret_kind_out = ret_kind_q;
	assign ret_wr_out = ret_wr_q;
	assign ri_exc_out = ri_q;
	assign addr_exc_out = addr_exc_q;
	assign cop_unusable_out = cpu_q;
	assign offset_out = ofs_q;
	assign branch_likely_ok_out = ~mode_q;

endmodule

`default_nettype wire

// *** tb/ism_mode_switch_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module ism_mode_switch_sva #(
	parameter int OFS_W = 26,
	parameter bit COMPACT_COP_RI = 1'b1
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [1:0] isa_avail_in,
	input wire logic exchange_jump_link_in,
	input wire logic rjump_in,
	input wire logic rjump_link_in,
	input wire logic [31:0] rjump_src_in,
	input wire logic exc_in,
	input wire logic [1:0] exc_kind_in,
	input wire logic [31:0] exc_pc_in,
	input wire logic eret_in,
	input wire logic [31:0] eret_addr_in,
	input wire logic cop_missing_in,
	input wire logic [OFS_W-1:0] offset_in,
	input wire logic mode_out,
	input wire logic [31:0] jump_target_out,
	input wire logic [31:0] link_value_out,
	input wire logic [31:0] ret_addr_out,
	input wire logic [1:0] ret_kind_out,
	input wire logic ret_wr_out,
	input wire logic ri_exc_out,
	input wire logic cop_unusable_out,
	input wire logic [31:0] offset_out,
	input wire logic branch_likely_ok_out
);
	logic [1:0] avail_q;
	logic hi;
	logic busy;
	// strap copy, only meaningful once reset has been seen
	always_ff @(posedge ref_clk_in) if (srst_in) avail_q <= isa_avail_in;
	assign hi = exc_in | eret_in;
	assign busy = hi | rjump_in | rjump_link_in;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);
	////////////////////////////////////////////////////////////////////////////////
	AST_RST_MODE: assert property ($fell(srst_in) |-> mode_out == avail_q[0])
		else $error("start mode wrong");
	AST_SINGLE_FIXED: assert property (!avail_q[1] |-> mode_out == avail_q[0])
		else $error("fixed mode moved");
	AST_RET_SAVE: assert property (exc_in |=> ret_wr_out
		&& ret_addr_out == {$past(exc_pc_in[31:1]), $past(mode_out)}) else $error("return save bad");
	AST_RET_KIND: assert property (exc_in |=> ret_kind_out == $past(exc_kind_in))
		else $error("return kind bad");
	AST_JUMP_TGT: assert property ((rjump_in || rjump_link_in) && !hi |=>
		jump_target_out == {$past(rjump_src_in[31:1]), 1'b0}
		&& (!avail_q[1] || mode_out == $past(rjump_src_in[0]))) else $error("register jump bad");
	AST_LINK_MODE: assert property (rjump_link_in && !hi |=>
		link_value_out[0] == $past(mode_out)) else $error("link mode bad");
	AST_XJ_TOGGLE: assert property (exchange_jump_link_in && !busy && avail_q[1] |=>
		mode_out != $past(mode_out)) else $error("exchange jump no toggle");
	AST_XJ_RI: assert property (exchange_jump_link_in && !busy && !avail_q[1] |=> ri_exc_out)
		else $error("exchange jump not refused");
	AST_ERET: assert property (eret_in && !exc_in && avail_q[1] |=>
		mode_out == $past(eret_addr_in[0])) else $error("return mode bad");
	AST_HOLD: assert property (!(busy || exchange_jump_link_in) |=> $stable(mode_out))
		else $error("mode moved without commit");
	AST_OFS: assert property (1'b1 |=> offset_out ==
		(32'($signed($past(offset_in))) << ($past(mode_out) ? 1 : 2))) else $error("offset bad");
	AST_COP: assert property (cop_missing_in |=>
		(($past(mode_out) && COMPACT_COP_RI) ? ri_exc_out : cop_unusable_out))
		else $error("coprocessor fault bad");
	AST_BLIKELY: assert property (branch_likely_ok_out == !mode_out)
		else $error("branch likely flag bad");
endmodule
bind ism_mode_switch ism_mode_switch_sva #(.OFS_W(OFS_W), .COMPACT_COP_RI(COMPACT_COP_RI))
	ism_mode_switch_sva_inst (.ref_clk_in, .srst_in, .isa_avail_in, .exchange_jump_link_in, .rjump_in,
	.rjump_link_in, .rjump_src_in, .exc_in, .exc_kind_in, .exc_pc_in, .eret_in, .eret_addr_in,
	.cop_missing_in, .ret_kind_out,
	.offset_in, .mode_out, .jump_target_out, .link_value_out, .ret_addr_out, .ret_wr_out,
	.ri_exc_out, .cop_unusable_out, .offset_out, .branch_likely_ok_out);
`default_nettype wire

// *** tb/ism_pipe_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ism_pipe_model (
	input wire logic ref_clk_in,
	output logic [6:0] ev_out,
	output logic [31:0] data_out
);
	initial begin
		ev_out = 7'h00;
		data_out = 32'h0000_0000;
	end
	// one commit pulse; operand bus inverted after, so no stale copy lingers
	task automatic issue(input int k, input logic [31:0] d);
		@(posedge ref_clk_in);
		ev_out <= 7'(1 << k);
		data_out <= d;
		@(posedge ref_clk_in);
		ev_out <= 7'h00;
		data_out <= ~d;
	endtask
endmodule
`default_nettype wire

// *** tb/ism_mode_switch_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ism_mode_switch_tb;
	import ism_pkg::*;
	logic ref_clk_in, srst_in, exc_sel_rst_in, dbg_sel_rst_in, avs_read, avs_write;
	logic exc_base_vec_in, avs_waitrequest, mode_out, ret_wr_out, ri_exc_out, addr_exc_out;
	logic cop_unusable_out, branch_likely_ok_out, ev_d, m, dual, pend;
	logic [1:0] isa_avail_in, ret_kind_out;
	logic [0:0] vpe_in;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, link_addr_in, avs_readdata, jump_target_out, link_value_out;
	logic [31:0] ret_addr_out, offset_out, pdata, d, q[$];
	logic [25:0] offset_in;
	logic [6:0] ev;
	ism_exc_kind_t exc_kind_in;
	int fails, check_count, cyc;
	initial begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	ism_mode_switch ism_mode_switch_inst (.ref_clk_in, .srst_in, .isa_avail_in, .exc_sel_rst_in,
		.dbg_sel_rst_in, .vpe_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .exchange_jump_link_in(ev[0]), .rjump_in(ev[1]),
		.rjump_link_in(ev[2]), .rjump_src_in(pdata), .link_addr_in, .exc_in(ev[3]), .exc_kind_in,
		.exc_base_vec_in, .exc_pc_in(pdata), .eret_in(ev[4]), .eret_addr_in(pdata),
		.fetch_in(ev[5]), .cop_missing_in(ev[6]), .offset_in, .mode_out, .jump_target_out,
		.link_value_out, .ret_addr_out, .ret_kind_out, .ret_wr_out, .ri_exc_out, .addr_exc_out,
		.cop_unusable_out, .offset_out, .branch_likely_ok_out);
	ism_pipe_model ism_pipe_model_inst (.ref_clk_in, .ev_out(ev), .data_out(pdata));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want) begin
			fails++;
			$display("ERROR %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		@(posedge ref_clk_in);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge ref_clk_in); while (avs_waitrequest);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] want);
		q.push_back(want);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic ev_go(input int k, input logic [31:0] v, input logic want);
		if (k < 6) q.push_back({30'h0, k == 5 && pend, want});
		offset_in <= 26'($urandom);
		link_addr_in <= $urandom;
		ism_pipe_model_inst.issue(k, v);
	endtask
	// monitor: each read answer or committed event other than missing coprocessor retires the oldest note
	always @(posedge ref_clk_in) begin
		ev_d <= |ev[5:0];
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			stop_test();
		end
		if ((avs_read && !avs_waitrequest) || ev_d)
			check(ev_d ? {30'h0, addr_exc_out, mode_out} : avs_readdata, q.pop_front());
	end
	initial begin
		{srst_in, avs_read, avs_write, exc_base_vec_in, ev_d, vpe_in} = 6'h20;
		{isa_avail_in, exc_sel_rst_in, dbg_sel_rst_in, avs_address, offset_in} = '0;
		{avs_writedata, link_addr_in} = '0;
		exc_kind_in = ISM_EXC_NORMAL;
		void'($urandom(67));
		for (int a = 0; a < 4; a++) begin
			@(posedge ref_clk_in);
			srst_in <= 1'b1;
			isa_avail_in <= 2'(a);
			exc_sel_rst_in <= 1'($urandom);
			dbg_sel_rst_in <= 1'($urandom);
			vpe_in <= 1'b0;
			repeat (12) @(posedge ref_clk_in);
			srst_in <= 1'b0;
			dual = isa_avail_in[1];
			m = isa_avail_in[0];
			pend = 1'b0;
			rd(4'h0, {15'h0, exc_sel_rst_in, isa_avail_in, 14'h0});
			rd(4'h4, {31'h0, dbg_sel_rst_in});
			rd(4'hc, 32'h0);
			rd(4'h8, {28'h0, isa_avail_in, 1'b0, m});
			if (dual) m = !m;
			ev_go(0, $urandom, m);
			d = $urandom;
			if (dual) m = d[0];
			ev_go(2, d, m);
			pend = !dual && d[0] != m;
			rd(4'h8, {28'h0, isa_avail_in, pend, m});
			ev_go(5, 32'h0, m);
			pend = 1'b0;
			rd(4'h8, {28'h0, isa_avail_in, 1'b0, m});
			d = $urandom;
			if (dual) m = d[0];
			ev_go(1, d, m);
			bus(1'b1, 4'h4, {31'h0, !dbg_sel_rst_in});
			exc_kind_in <= ISM_EXC_DEBUG;
			if (dual) m = !dbg_sel_rst_in;
			ev_go(3, $urandom, m);
			d = $urandom;
			if (dual) m = d[0];
			ev_go(4, d, m);
			vpe_in <= 1'b1;
			bus(1'b1, 4'h0, {15'h0, !exc_sel_rst_in, 16'h0});
			rd(4'h0, {15'h0, !exc_sel_rst_in, isa_avail_in, 14'h0});
			vpe_in <= 1'b0;
			rd(4'h0, {15'h0, exc_sel_rst_in, isa_avail_in, 14'h0});
			vpe_in <= 1'b1;
			exc_kind_in <= ISM_EXC_NORMAL;
			exc_base_vec_in <= 1'b1;
			if (dual) m = !exc_sel_rst_in;
			ev_go(3, $urandom, m);
			exc_kind_in <= ISM_EXC_ERROR;
			exc_base_vec_in <= 1'b0;
			if (dual) m = isa_avail_in[0];
			ev_go(3, $urandom, m);
			ev_go(6, 32'h0, m);
			repeat (3) @(posedge ref_clk_in);
			$display("test with encodings code %0d done", a);
		end
		stop_test();
	end
endmodule
`default_nettype wire
